// >>> core/sci_rx_pkg.sv
// Purpose: Shared constants and types of the serial receiver.
// Assumes: 100 MHz bus clock, 32-bit AXI4-Lite register access.
// Notes: Sample ticks run at sixteen per bit time.
package sci_rx_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam logic [7:0] SERIAL_CONTROL_ONE_OFS = 8'h00;
  localparam logic [7:0] SERIAL_STATUS_ONE_OFS = 8'h04;
  localparam logic [7:0] RECEIVE_DATA_BUFFER_OFS = 8'h08;
  localparam logic [7:0] BAUD_DIVISOR_OFS = 8'h0c;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // Control bits
  // ---------------------------------------------------------------
  localparam int C_NINE_BIT = 0;
  localparam int C_WAKE_ADDR = 1;
  localparam int C_QUIET_START = 2;
  localparam int C_PAR_EN = 3;
  localparam int C_PAR_ODD = 4;
  localparam int C_RX_EN = 5;
  localparam int C_STANDBY = 6;
  localparam int C_FULL_IE = 7;
  localparam int C_QUIET_IE = 8;
  localparam int C_OVR_IE = 9;
  localparam int C_NOISE_IE = 10;
  localparam int C_FRAME_IE = 11;
  localparam int C_PAR_IE = 12;
  localparam int CTL_W = 13;
  // ---------------------------------------------------------------
  // Status bits
  // ---------------------------------------------------------------
  localparam int S_FULL = 0;
  localparam int S_QUIET = 1;
  localparam int S_OVR = 2;
  localparam int S_NOISE = 3;
  localparam int S_FRAME = 4;
  localparam int S_PAR = 5;
  localparam int S_BRK = 6;
  localparam int STF_W = 7;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_RST = 9600;
  localparam int RT_PER_BIT = 16;
  localparam logic [15:0] DIV_RST = 16'(CLK_HZ / (RT_PER_BIT * BAUD_RST) - 1);
  localparam logic [4:0] RT_FIRST = 5'h01;
  localparam logic [4:0] RT_V1 = 5'h03;
  localparam logic [4:0] RT_V2 = 5'h05;
  localparam logic [4:0] RT_V3 = 5'h07;
  localparam logic [4:0] RT_S1 = 5'h08;
  localparam logic [4:0] RT_S2 = 5'h09;
  localparam logic [4:0] RT_S3 = 5'h0a;
  localparam logic [4:0] RT_LAST = 5'h10;
  localparam logic [3:0] STOP_IDX8 = 4'h9;
  localparam logic [3:0] STOP_IDX9 = 4'ha;
  localparam logic [7:0] QUIET_TICKS8 = 8'ha0;
  localparam logic [7:0] QUIET_TICKS9 = 8'hb0;
  localparam int STOP_T8 = 9 * RT_PER_BIT + 10;
  localparam int STOP_T9 = 10 * RT_PER_BIT + 10;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10
  } rx_state_t;

  function automatic logic maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic split3(input logic [2:0] s);
    return (s != 3'b000) && (s != 3'b111);
  endfunction
endpackage

// >>> core/sci_receiver_errors_wakeup.sv
// Purpose: Asynchronous serial receiver with error flags and wakeup.
// Assumes: rxd is asynchronous; mode inputs are on the aclk domain.
// Notes: Status flags clear by a status read, then a data read.
// Function
// - Missing stop bit sets framing error flag
// - Break character also sets framing error
// - Framing error appears with receiver full
// - One bad stop sample noise, two framing
// - Resynchronise sample phase on falling edges
// - 8-bit stop sampling ends at 154
// - 9-bit stop sampling ends at 170
// - Standby bit mutes all receiver interrupts
// - Address mark clears standby, sets full
// - Waking idle clears standby, no flags
// - Quiet count starts after start/stop
// - Completed character sets receiver full flag
// - Idle flag after 10/11 ones
// - Overrun keeps old character, drops new
// - Noise on any bit sets noise
// - Parity mismatch sets parity error flag
// - Wait mode runs, blocks registers, wakes
// - Stop mode halts, keeps registers
// - Break without permission freezes flags
// - Break with permission lets clears stick
// - Sixteen ticks per bit, samples 8-10
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
module sci_receiver_errors_wakeup (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // synchronous reset
  input wire logic [sci_rx_pkg::AXI_AW-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [sci_rx_pkg::AXI_AW-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic rxd, // receive line
  input wire logic wait_mode, // processor waits
  input wire logic stop_mode, // clocks halted
  input wire logic break_state, // debug break active
  input wire logic break_clear_allow, // clears allowed in break
  output logic rx_irq, // receive request
  output logic err_irq, // error request
  output logic wake_req // any enabled request
);
  import sci_rx_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic rx_s1;
    logic rx_s2;
    logic [2:0] hist;
    logic [15:0] pre;
    logic [15:0] div;
    logic [CTL_W-1:0] ctl;
    logic [STF_W-1:0] st;
    logic [STF_W-1:0] arm;
    logic [8:0] dat;
    rx_state_t rs;
    logic [4:0] rt;
    logic [3:0] bit_n;
    logic [2:0] smp;
    logic [8:0] sh;
    logic last1;
    logic nz;
    logic [7:0] ones;
    logic armed;
    logic [7:0] tcnt;
    logic rsy;
    logic aw_ok;
    logic [AXI_AW-1:0] awa;
    logic w_ok;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } state_t;

  state_t q;
  state_t d;
  logic line;
  logic [2:0] cur;
  logic tick;
  logic fall;
  logic count_ok;
  logic quiet_hit;
  logic done;
  logic stop_v;
  logic vote;
  logic par_bad;
  logic msb;
  logic am_wake;
  logic il_wake;
  logic deliver;
  logic ovr;
  logic clr_ok;
  logic [3:0] stop_n;
  logic [7:0] lim;

  assign line = q.rx_s2;
  assign cur = {q.smp[1:0], line};

  always_comb begin
    d = q;
    // A divisor written below the running count takes effect at once.
    tick = (q.pre >= q.div) && !stop_mode;
    fall = q.hist[0] && !line;
    count_ok = 1'b0;
    quiet_hit = 1'b0;
    done = 1'b0;
    stop_v = 1'b1;
    vote = 1'b0;
    am_wake = 1'b0;
    il_wake = 1'b0;
    deliver = 1'b0;
    ovr = 1'b0;
    clr_ok = !break_state || break_clear_allow;
    stop_n = q.ctl[C_NINE_BIT] ? STOP_IDX9 : STOP_IDX8;
    lim = q.ctl[C_NINE_BIT] ? QUIET_TICKS9 : QUIET_TICKS8;
    msb = q.ctl[C_NINE_BIT] ? q.sh[8] : q.sh[7];
    par_bad = q.ctl[C_PAR_EN] &&
              ((^(q.sh & {q.ctl[C_NINE_BIT], 8'hff})) != q.ctl[C_PAR_ODD]);
    d.rx_s1 = rxd;
    d.rx_s2 = q.rx_s1;
    // Stop mode freezes the tick divider; registers keep their values.
    if (!stop_mode) begin
      d.pre = tick ? 16'h0000 : q.pre + 16'h0001;
    end

    // ---------------------------------------------------------------
    // Register bus
    // ---------------------------------------------------------------
    if (q.bv && bready) begin
      d.bv = 1'b0;
    end
    if (q.rv && rready) begin
      d.rv = 1'b0;
    end
    if (awvalid && awready) begin
      d.aw_ok = 1'b1;
      d.awa = awaddr;
    end
    if (wvalid && wready) begin
      d.w_ok = 1'b1;
      d.wd = wdata;
      d.ws = wstrb;
    end
    if (q.aw_ok && q.w_ok) begin
      d.aw_ok = 1'b0;
      d.w_ok = 1'b0;
      d.bv = 1'b1;
      d.br = RESP_OK;
      // Registers are closed to the processor while it waits.
      if (wait_mode) begin
        d.br = RESP_SLVERR;
      end else begin
        case (q.awa)
          SERIAL_CONTROL_ONE_OFS: begin
            if (q.ws[0]) d.ctl[7:0] = q.wd[7:0];
            if (q.ws[1]) d.ctl[CTL_W-1:8] = q.wd[CTL_W-1:8];
          end
          BAUD_DIVISOR_OFS: begin
            if (q.ws[0]) d.div[7:0] = q.wd[7:0];
            if (q.ws[1]) d.div[15:8] = q.wd[15:8];
          end
          SERIAL_STATUS_ONE_OFS, RECEIVE_DATA_BUFFER_OFS: begin
          end
          default: begin
            d.br = RESP_SLVERR;
          end
        endcase
      end
    end
    if (arvalid && arready) begin
      d.rv = 1'b1;
      d.rr = RESP_OK;
      d.rd = 32'h0000_0000;
      if (wait_mode) begin
        d.rr = RESP_SLVERR;
      end else begin
        case (araddr)
          SERIAL_CONTROL_ONE_OFS: begin
            d.rd = {19'h0, q.ctl};
          end
          SERIAL_STATUS_ONE_OFS: begin
            d.rd = {24'h0, q.rs != RX_HUNT, q.st};
            // First clearing step; held back in a protected break.
            if (clr_ok) d.arm = q.st;
          end
          RECEIVE_DATA_BUFFER_OFS: begin
            d.rd = {23'h0, q.dat};
            // Second step clears what the status read armed.
            if (clr_ok) begin
              d.st = q.st & ~q.arm;
              d.arm = '0;
            end
          end
          BAUD_DIVISOR_OFS: begin
            d.rd = {16'h0, q.div};
          end
          default: begin
            d.rr = RESP_SLVERR;
          end
        endcase
      end
    end

    // ---------------------------------------------------------------
    // Receiver, advanced once per sample tick
    // ---------------------------------------------------------------
    if (tick) begin
      d.hist = {q.hist[1:0], line};
      d.tcnt = q.tcnt + 8'h01;
      case (q.rs)
        RX_HUNT: begin
          // A low after three highs is a candidate start edge.
          if (!line && (&q.hist)) begin
            d.rs = RX_START;
            d.rt = RT_FIRST;
            d.nz = 1'b0;
            d.smp = 3'b000;
            d.sh = 9'h000;
            d.last1 = 1'b0;
            d.tcnt = 8'h01;
            d.rsy = 1'b0;
          end
        end
        RX_START: begin
          d.rt = q.rt + 5'h01;
          if (q.rt == RT_V1 || q.rt == RT_V2 || q.rt == RT_V3 ||
              q.rt == RT_S1 || q.rt == RT_S2 || q.rt == RT_S3) begin
            d.smp = cur;
          end
          if (q.rt == RT_V3) begin
            if (maj3(cur)) begin
              d.rs = RX_HUNT;
            end else begin
              d.nz = split3(cur);
            end
          end
          if (q.rt == RT_S3 && cur != 3'b000) begin
            d.nz = 1'b1;
          end
          if (q.rt == RT_LAST) begin
            d.rs = RX_BITS;
            d.rt = RT_FIRST;
            d.bit_n = 4'h1;
            d.armed = 1'b1;
          end
        end
        RX_BITS: begin
          d.rt = (q.rt == RT_LAST) ? RT_FIRST : q.rt + 5'h01;
          if (q.rt == RT_LAST) begin
            d.bit_n = q.bit_n + 4'h1;
          end
          if (q.rt == RT_S1 || q.rt == RT_S2 || q.rt == RT_S3) begin
            d.smp = cur;
          end
          if (q.rt == RT_S3) begin
            vote = maj3(cur);
            d.last1 = vote;
            if (split3(cur)) begin
              d.nz = 1'b1;
            end
            if (q.bit_n == stop_n) begin
              done = 1'b1;
              stop_v = vote;
              d.rs = RX_HUNT;
            end else begin
              d.sh[q.bit_n - 4'h1] = vote;
            end
          end
          // A one-to-zero change restarts the bit phase; late edges
          // belong to the next bit, early ones to the current bit.
          if (fall && q.last1 && q.rt != RT_LAST &&
              (q.rt > RT_S3 || q.rt < RT_S1)) begin
            d.rt = RT_FIRST;
            d.rsy = 1'b1;
            if (q.rt > RT_S3) begin
              d.bit_n = q.bit_n + 4'h1;
            end
          end
        end
        default: begin
          d.rs = RX_HUNT;
        end
      endcase

      // Quiet-line counting of consecutive high ticks.
      count_ok = q.ctl[C_QUIET_START] ? (q.rs == RX_HUNT)
                                      : (q.rs != RX_START);
      if (!line) begin
        d.ones = 8'h00;
      end else if (count_ok && q.ones < lim) begin
        d.ones = q.ones + 8'h01;
        quiet_hit = (q.ones + 8'h01) == lim;
      end
    end

    // ---------------------------------------------------------------
    // Character delivery and wakeup
    // ---------------------------------------------------------------
    am_wake = done && q.ctl[C_STANDBY] && q.ctl[C_WAKE_ADDR] && msb;
    deliver = done && (!q.ctl[C_STANDBY] || am_wake);
    if (am_wake) begin
      d.ctl[C_STANDBY] = 1'b0;
    end
    if (deliver) begin
      // Judged after any clear in this cycle, so a read that empties
      // the buffer in the same cycle avoids a false overrun.
      if (d.st[S_FULL]) begin
        ovr = 1'b1;
        d.st[S_OVR] = 1'b1;
      end else begin
        d.dat = q.ctl[C_NINE_BIT] ? q.sh : {q.sh[7], q.sh[7:0]};
        d.st[S_FULL] = 1'b1;
        d.st[S_FRAME] = d.st[S_FRAME] | !stop_v;
        d.st[S_NOISE] = d.st[S_NOISE] | d.nz;
        d.st[S_PAR] = d.st[S_PAR] | par_bad;
        d.st[S_BRK] = d.st[S_BRK] | (!stop_v && q.sh == 9'h000);
      end
    end
    // Setting standby on a line already counted quiet does not wake until a low restarts the count.
    il_wake = quiet_hit && q.ctl[C_STANDBY] && !q.ctl[C_WAKE_ADDR];
    if (il_wake) begin
      d.ctl[C_STANDBY] = 1'b0;
    end else if (quiet_hit && q.armed && !q.ctl[C_STANDBY]) begin
      d.st[S_QUIET] = 1'b1;
      d.armed = 1'b0;
    end

    // A halted clock aborts any character in progress; the receiver returns to hunting.
    if (!q.ctl[C_RX_EN] || stop_mode) begin
      d.rs = RX_HUNT;
    end
    if (!q.ctl[C_RX_EN]) begin
      d.ones = 8'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.div <= DIV_RST;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign awready = !q.aw_ok && !q.bv;
  assign wready = !q.w_ok && !q.bv;
  assign bvalid = q.bv;
  assign bresp = q.br;
  assign arready = !q.rv;
  assign rvalid = q.rv;
  assign rdata = q.rd;
  assign rresp = q.rr;
  assign rx_irq = !q.ctl[C_STANDBY] &&
                  ((q.st[S_FULL] && q.ctl[C_FULL_IE]) ||
                   (q.st[S_QUIET] && q.ctl[C_QUIET_IE]));
  assign err_irq = !q.ctl[C_STANDBY] &&
                   (|(q.st[S_PAR:S_OVR] & q.ctl[C_PAR_IE:C_OVR_IE]));
  // Wakes a waiting processor; this path needs no register access.
  assign wake_req = rx_irq || err_irq;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_frame_with_full: assert property (
    $rose(q.st[S_FRAME]) |-> q.st[S_FULL] && $past(deliver) && !$past(ovr))
    else $error("framing flag rose without receiver full");
  a_bad_stop_frames: assert property (
    deliver && !ovr && !stop_v |=> q.st[S_FRAME] && q.st[S_FULL])
    else $error("missing stop bit not flagged");
  a_stop_time_8: assert property (
    done && !q.rsy && !q.ctl[C_NINE_BIT] |-> q.tcnt == STOP_T8)
    else $error("8-bit stop sampling not at 154 ticks");
  a_stop_time_9: assert property (
    done && !q.rsy && q.ctl[C_NINE_BIT] |-> q.tcnt == STOP_T9)
    else $error("9-bit stop sampling not at 170 ticks");
  a_standby_mute: assert property (
    q.ctl[C_STANDBY] |-> !rx_irq && !err_irq && !wake_req)
    else $error("request raised in standby");
  a_mark_wakes: assert property (
    am_wake |=> !q.ctl[C_STANDBY] && q.st[S_FULL])
    else $error("address mark did not wake");
  a_quiet_wake: assert property (
    il_wake |=> !q.ctl[C_STANDBY] && !$rose(q.st[S_QUIET]) &&
    !$rose(q.st[S_FULL]))
    else $error("waking idle misbehaved");
  a_overrun_keeps: assert property (
    ovr |=> q.st[S_OVR] && $stable(q.dat))
    else $error("overrun altered the buffer");
  a_break_frozen: assert property (
    break_state && !break_clear_allow |=>
    (q.st & $past(q.st)) == $past(q.st))
    else $error("flag cleared during protected break");

  c_char: cover property (deliver && !ovr && stop_v);
  c_break: cover property (deliver && !stop_v && q.sh == 9'h000);
  c_idle_wake: cover property (il_wake);
endmodule

// >>> sim/serial_tx_model.sv
// Purpose: Far-end asynchronous transmitter that drives the receive line.
// Assumes: Divisor 0, so one bit lasts bit_len aclk cycles.
// Notes: stop_kind 0 good stop, 1 low stop, 2 one-tick low glitch.
module serial_tx_model (
  input wire logic aclk, // bench clock
  input wire logic go, // start one frame
  input wire logic [8:0] data, // character, sent LSB first
  input wire logic nine, // nine data bits
  input wire logic [1:0] stop_kind, // shape of the stop bit
  input wire logic [4:0] bit_len, // cycles per bit
  output logic rxd, // serial line
  output logic busy // frame on the line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] fr;
  int n;
  initial begin
    rxd = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge aclk);
      if (go) begin
        busy <= 1'b1;
        n = nine ? 9 : 8;
        fr = nine ? {data, 1'b0} : {1'b0, data[7:0], 1'b0};
        for (int i = 0; i <= n + 1; i++) begin
          for (int t = 0; t < int'(bit_len); t++) begin
            // The glitch sits mid-window so only one stop sample sees it.
            if (i <= n)
              rxd <= fr[i];
            else
              rxd <= stop_kind != 2'h1 && !(stop_kind == 2'h2 && t == 9);
            @(posedge aclk);
          end
        end
        // The line idles high, so a standby receiver set for idle-line wakeup wakes once the quiet count reaches its limit.
        rxd <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule

// >>> sim/tb.sv
// Purpose: Self-checking bench of the serial receiver.
// Assumes: Divisor set to 0 after reset, one sample tick per aclk.
// Notes: Status compares mask the live receiving and quiet bits, save the reset check and the idle wake check.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sci_rx_pkg::*;
  typedef struct {
    logic [8:0] d;
    logic nine, pen, odd;
    logic [1:0] sk;
    logic [4:0] bl;
    logic [7:0] st;
  } row_t;
  row_t rows [11] = '{
    '{9'h0a5, 0, 0, 0, 0, 16, 8'h01}, '{9'h1a5, 1, 0, 0, 0, 16, 8'h01},
    '{9'h035, 0, 1, 0, 0, 16, 8'h01}, '{9'h0b5, 0, 1, 0, 0, 16, 8'h21},
    '{9'h0b5, 0, 1, 1, 0, 16, 8'h01}, '{9'h0a5, 1, 1, 1, 0, 16, 8'h21},
    '{9'h05a, 0, 0, 0, 1, 16, 8'h11}, '{9'h000, 0, 0, 0, 1, 16, 8'h51},
    '{9'h00f, 0, 0, 0, 2, 16, 8'h09}, '{9'h055, 0, 0, 0, 0, 17, 8'h01},
    '{9'h055, 0, 0, 0, 0, 15, 8'h01}};
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic wait_mode = 1'b0, stop_mode = 1'b0;
  logic break_state = 1'b0, break_clear_allow = 1'b0;
  logic tx_go = 1'b0, tx_nine = 1'b0;
  logic [8:0] tx_d = 9'h0;
  logic [1:0] tx_sk = 2'h0;
  logic [4:0] tx_bl = 5'h10;
  logic awready, wready, bvalid, arready, rvalid;
  logic rxd, busy, rx_irq, err_irq, wake_req;
  logic [1:0] bresp, rresp, rr, br;
  logic [31:0] rdata, rv;
  int failures = 0, n_compared = 0, cyc = 0, lat;
  int lt [2];

  always #5 aclk = ~aclk;

  sci_receiver_errors_wakeup i_dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .rxd(rxd), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .break_state(break_state),
    .break_clear_allow(break_clear_allow), .rx_irq(rx_irq),
    .err_irq(err_irq), .wake_req(wake_req));

  serial_tx_model i_far (.aclk(aclk), .go(tx_go), .data(tx_d),
    .nine(tx_nine), .stop_kind(tx_sk), .bit_len(tx_bl), .rxd(rxd),
    .busy(busy));

  // ---------------------------------------------------------------
  // Bus and line tasks
  // ---------------------------------------------------------------
  // Handshakes are judged at the falling edge, where ready and valid
  // already hold the values that the next rising edge will sample.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid === 1'b1;
      br = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic ah, rh;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge aclk);
      ah = arvalid && arready;
      rh = rvalid === 1'b1;
      rv = rdata;
      rr = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
    end
  endtask

  task automatic send(input logic [8:0] d, input logic nine,
                      input logic [1:0] sk, input logic [4:0] bl);
    int n;
    repeat (6) @(posedge aclk);
    tx_d <= d;
    tx_nine <= nine;
    tx_sk <= sk;
    tx_bl <= bl;
    tx_go <= 1'b1;
    @(posedge aclk);
    tx_go <= 1'b0;
    n = 0;
    lat = 0;
    do begin
      @(negedge aclk);
      n++;
      if (rx_irq === 1'b1 && lat == 0) lat = n;
    end while (busy !== 1'b0);
    @(posedge aclk);
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00);
    chk("control reset", rv, 32'h0);
    rd(8'h04);
    chk("status reset", rv, 32'h0);
    rd(8'h0c);
    chk("divisor reset", rv, 32'h28a);
    rd(8'h10);
    chk("unmapped resp", 32'(rr), 32'(RESP_SLVERR));
    chk("unmapped data", rv, 32'h0);
    wr(8'h0c, 32'h0);
    chk("write resp", 32'(br), 32'(RESP_OK));
    foreach (rows[i]) begin
      wr(8'h00, 32'h0a0 | {27'h0, rows[i].odd, rows[i].pen, 2'h0,
                           rows[i].nine});
      send(rows[i].d, rows[i].nine, rows[i].sk, rows[i].bl);
      if (i < 2) lt[i] = lat;
      rd(8'h04);
      chk("status", rv & 32'h7d, 32'(rows[i].st));
      rd(8'h08);
      chk("data", rv, rows[i].nine ? 32'(rows[i].d) :
          32'({rows[i].d[7], rows[i].d[7:0]}));
      chk("rx request cleared", 32'(rx_irq), 32'h0);
    end
    chk("stop time 8", 32'(lt[0] > 154 && lt[0] < 161), 32'h1);
    chk("stop time 9", 32'(lt[1] - lt[0]), 32'd16);
    wr(8'h00, 32'h220);
    send(9'h011, 1'b0, 2'h0, 5'h10);
    send(9'h022, 1'b0, 2'h0, 5'h10);
    chk("error request", 32'(err_irq), 32'h1);
    wr(8'h00, 32'h262);
    chk("muted request", 32'(err_irq), 32'h0);
    wr(8'h00, 32'h220);
    wait_mode <= 1'b1;
    rd(8'h04);
    chk("wait resp", 32'(rr), 32'(RESP_SLVERR));
    chk("wait wake", 32'(wake_req), 32'h1);
    wr(8'h00, 32'h0);
    chk("wait write", 32'(br), 32'(RESP_SLVERR));
    wait_mode <= 1'b0;
    rd(8'h00);
    chk("wait kept control", rv, 32'h220);
    rd(8'h04);
    chk("overrun status", rv & 32'h7d, 32'h05);
    rd(8'h08);
    chk("overrun data", rv, 32'h011);
    chk("error cleared", 32'(err_irq), 32'h0);
    wr(8'h00, 32'h0e2);
    send(9'h005, 1'b0, 2'h0, 5'h10);
    chk("standby quiet", 32'(rx_irq), 32'h0);
    rd(8'h04);
    chk("standby drop", rv & 32'h7d, 32'h0);
    send(9'h085, 1'b0, 2'h0, 5'h10);
    rd(8'h00);
    chk("address wake", 32'(rv[C_STANDBY]), 32'h0);
    rd(8'h04);
    chk("address full", rv & 32'h7d, 32'h01);
    rd(8'h08);
    chk("address data", rv, 32'h185);
    wr(8'h00, 32'h060);
    repeat (200) @(posedge aclk);
    rd(8'h00);
    chk("idle wake", 32'(rv[C_STANDBY]), 32'h0);
    rd(8'h04);
    chk("idle wake flags", rv & 32'h3, 32'h0);
    for (int s = 0; s < 2; s++) begin
      wr(8'h00, 32'h120 | (s << 2));
      send(9'h0ff, 1'b0, 2'h0, 5'h10);
      repeat (80) @(posedge aclk);
      chk("quiet start", 32'(rx_irq), 32'(s == 0));
      repeat (200) @(posedge aclk);
      chk("quiet request", 32'(rx_irq), 32'h1);
      rd(8'h04);
      rd(8'h08);
    end
    wr(8'h00, 32'h020);
    for (int a = 0; a < 2; a++) begin
      send(9'h033, 1'b0, 2'h0, 5'h10);
      break_clear_allow <= a[0];
      break_state <= 1'b1;
      rd(8'h04);
      rd(8'h08);
      break_state <= 1'b0;
      rd(8'h04);
      chk("break full", 32'(rv[S_FULL]), 32'(a == 0));
      rd(8'h08);
    end
    wr(8'h00, 32'h0a1);
    tx_d <= 9'h1ff;
    tx_nine <= 1'b1;
    tx_go <= 1'b1;
    @(posedge aclk);
    tx_go <= 1'b0;
    repeat (50) @(posedge aclk);
    stop_mode <= 1'b1;
    repeat (100) @(posedge aclk);
    stop_mode <= 1'b0;
    repeat (160) @(posedge aclk);
    rd(8'h00);
    chk("stop keeps control", rv, 32'h0a1);
    rd(8'h04);
    chk("stop aborts char", rv & 32'h7d, 32'h0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00);
    chk("reset control", rv, 32'h0);
    rd(8'h0c);
    chk("reset divisor", rv, 32'h28a);
    close_out();
  end
endmodule
